/* File: hw/rcu_consts.svh */
// Constants of the clock calibration, unlock and event block.
// Included by both ends, the device and the host.
`ifndef RCU_CONSTS_SVH
`define RCU_CONSTS_SVH
`define RCU_A_CFG 8'hA1
`define RCU_A_HTH 8'hA2
`define RCU_A_SEC 8'hA3
`define RCU_A_MIN 8'hA4
`define RCU_A_HOUR 8'hA5
`define RCU_A_IVAL 8'hA6
`define RCU_A_IE2 8'hA9
`define RCU_A_KEY 8'hC1
`define RCU_A_PWR 8'hC5
`define RCU_A_NOM 8'hF6
`define RCU_A_TEMP 8'hF7
`define RCU_A_PIN 8'hFF
`define RCU_KEY_PWR 8'hA7
`define RCU_KEY_TIME 8'hEA
`define RCU_B_CALEN 7
`define RCU_B_MIDN 6
`define RCU_B_ALRM 5
`define RCU_B_TFH 4
`define RCU_B_ITEN 1
`define RCU_B_SIT 0
`define RCU_B_ETI 2
`define RCU_HOUR_24 8'h17
`define RCU_HOUR_256 8'hFF
`define RCU_HTH_LAST 8'h63
`define RCU_MS_LAST 8'h3B
`define RCU_STEP_NORM 16'h0064
`define RCU_STEP_FAST 16'h30D4
`define RCU_STEP_500 16'h03E8
`define RCU_COMP_LIM 9'sh07C
`define RCU_COMP_SCALE 18'sh00064
`define RCU_PULSE_PPM 18'sh005F6
`endif

/* File: hw/rcu_device.sv */
// Clock block end: trims, calibration pin, pin config, unlock key,
// timekeeping, 128 Hz config domain, midnight/alarm events.
// Assumes xtal_pulse is a one-cycle pulse per 32.768 kHz crystal edge.
`timescale 1ns/1ps
`include "rcu_consts.svh"

// Behaviour
// - temp trim survives warm resets only
// - cal enable drives cal frequency out
// - select field picks window and frequency
// - software keeps reserved bit four zero
// - irq1 function field decoded to pins
// - irq0 function bit enables irq0
// - key A7 unlocks power control write
// - key EA unlocks pin config, counters
// - counters crystal domain, config 128 Hz
// - config writes land within two ticks
// - software clears key after counter write
// - software rereads hundredths, repeats on change
// - midnight on hour wrap 23/255
// - midnight sets flag, pends interrupt
// - midnight in deep sleep wakes core
// - shared enable, vectoring clears pending
// - disabled pending stays until enabled
// - flags stay set until software clears
// - pending keeps waking until serviced
// - summed trims clamped, add/remove pulses
// - fast windows clock counters 125x
module rcu_device (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic warm_rst,
    rcu_if.device bus,
    input wire logic xtal_pulse,
    output logic cal_out,
    output logic cal_oe_n,
    output logic ext_irq0_enable,
    output logic ext_irq1_enable,
    output logic ext_irq1_gpio,
    output logic battery_control_input,
    output logic [7:0] power_control,
    output logic power_control_we
);
    typedef struct packed {
        logic [7:0] key;
        logic [7:0] temp;
        logic [7:0] nom;
        logic [7:0] pin;
        logic [7:0] cfg;
        logic [7:0] cfg_sh;
        logic cfg_dirty;
        logic [7:0] ival;
        logic [7:0] ival_sh;
        logic ival_dirty;
        logic [7:0] ie2;
        logic [7:0] hth;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [14:0] pre;
        logic [14:0] div;
        logic [14:0] c500;
        logic sq500;
        logic signed [17:0] cacc;
        logic ins_req;
        logic del_req;
        logic [7:0] itv;
        logic pend;
        logic wake;
        logic cal;
        logic [7:0] rdata;
        logic [7:0] pwr;
        logic pwr_we;
    } rcu_dev_s;

    rcu_dev_s r;
    rcu_dev_s next_r;

    logic eff;
    logic t128;
    logic hth_t;
    logic sec_t;
    logic min_t;
    logic hour_t;
    logic midnight;
    logic alarm;
    logic it_tick;
    logic [15:0] step;
    logic [15:0] pre_sum;
    logic [15:0] c5_sum;
    logic signed [8:0] comp;
    logic unlock_t;
    logic unlock_p;

    ////////////////////////////////////////////////////////////////////////////
    // Datapath
    always_comb begin
        next_r = r;
        next_r.pwr_we = 1'b0;
        // Positive trim sum means the crystal is slow: add pulses
        comp = $signed({r.temp[7], r.temp}) + $signed({r.nom[7], r.nom});
        if (comp > `RCU_COMP_LIM) comp = `RCU_COMP_LIM;
        if (comp < -`RCU_COMP_LIM) comp = -`RCU_COMP_LIM;
        eff = (xtal_pulse && !r.del_req) || (!xtal_pulse && r.ins_req);
        if (xtal_pulse && r.del_req) next_r.del_req = 1'b0;
        if (!xtal_pulse && r.ins_req) next_r.ins_req = 1'b0;
        // Fast windows speed the counters only; the divider stays true
        step = r.pin[6] ? `RCU_STEP_FAST : `RCU_STEP_NORM;
        pre_sum = {1'b0, r.pre} + step;
        c5_sum = {1'b0, r.c500} + `RCU_STEP_500;
        t128 = eff && (r.div[7:0] == 8'hFF);
        hth_t = eff && pre_sum[15];
        sec_t = hth_t && (r.hth == `RCU_HTH_LAST);
        min_t = sec_t && (r.sec == `RCU_MS_LAST);
        hour_t = min_t && (r.min == `RCU_MS_LAST);
        midnight = hour_t && (r.hour == (r.cfg[`RCU_B_TFH] ? `RCU_HOUR_24 : `RCU_HOUR_256));
        case (rcu_pkg::rcu_itbase_e'(r.cfg[3:2]))
            rcu_pkg::RCU_IT_128: it_tick = t128;
            rcu_pkg::RCU_IT_SEC: it_tick = sec_t;
            rcu_pkg::RCU_IT_MIN: it_tick = min_t;
            rcu_pkg::RCU_IT_HOUR: it_tick = hour_t;
            default: it_tick = 1'b0;
        endcase
        it_tick = it_tick && r.cfg[`RCU_B_ITEN] && !(r.cfg[`RCU_B_SIT] && r.cfg[`RCU_B_ALRM]);
        alarm = it_tick && (r.itv + 8'h01 == r.ival);

        if (eff) begin
            next_r.div = r.div + 15'h0001;
            next_r.pre = pre_sum[14:0];
            next_r.c500 = c5_sum[14:0];
            if (c5_sum[15]) next_r.sq500 = !r.sq500;
            if (r.div == 15'h7FFF) begin
                next_r.cacc = r.cacc + `RCU_COMP_SCALE * 18'(comp);
            end
        end
        if (r.cacc >= `RCU_PULSE_PPM) begin
            next_r.cacc = next_r.cacc - `RCU_PULSE_PPM;
            next_r.ins_req = 1'b1;
        end else if (r.cacc <= -`RCU_PULSE_PPM) begin
            next_r.cacc = next_r.cacc + `RCU_PULSE_PPM;
            next_r.del_req = 1'b1;
        end
        if (hth_t) next_r.hth = sec_t ? 8'h00 : r.hth + 8'h01;
        if (sec_t) next_r.sec = min_t ? 8'h00 : r.sec + 8'h01;
        if (min_t) next_r.min = hour_t ? 8'h00 : r.min + 8'h01;
        if (hour_t) next_r.hour = midnight ? 8'h00 : r.hour + 8'h01;
        if (it_tick) next_r.itv = alarm ? 8'h00 : r.itv + 8'h01;
        // Staged config reaches the clock domain on the next 128 Hz tick
        if (t128 && r.cfg_dirty) begin
            next_r.cfg[4:0] = r.cfg_sh[4:0];
            next_r.cfg_dirty = 1'b0;
        end
        if (t128 && r.ival_dirty) begin
            next_r.ival = r.ival_sh;
            next_r.ival_dirty = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // Register writes
        unlock_t = (r.key == `RCU_KEY_TIME);
        unlock_p = (r.key == `RCU_KEY_PWR);
        if (bus.sfr_we) begin
            case (bus.sfr_addr)
                `RCU_A_KEY: next_r.key = bus.sfr_wdata;
                `RCU_A_TEMP: next_r.temp = bus.sfr_wdata;
                `RCU_A_NOM: next_r.nom = bus.sfr_wdata;
                `RCU_A_IE2: next_r.ie2 = bus.sfr_wdata;
                `RCU_A_CFG: begin
                    next_r.cfg_sh = bus.sfr_wdata;
                    next_r.cfg_dirty = 1'b1;
                    // Flags clear at once by writing zero to them
                    next_r.cfg[6:5] = r.cfg[6:5] & bus.sfr_wdata[6:5];
                end
                `RCU_A_IVAL: begin
                    next_r.ival_sh = bus.sfr_wdata;
                    next_r.ival_dirty = 1'b1;
                end
                `RCU_A_PWR: begin
                    if (unlock_p) begin
                        next_r.pwr = bus.sfr_wdata;
                        next_r.pwr_we = 1'b1;
                        next_r.key = 8'h00;
                    end
                end
                `RCU_A_PIN, `RCU_A_HTH, `RCU_A_SEC, `RCU_A_MIN, `RCU_A_HOUR: begin
                    if (unlock_t) begin
                        next_r.key = 8'h00;
                        case (bus.sfr_addr)
                            `RCU_A_PIN: next_r.pin = bus.sfr_wdata;
                            `RCU_A_HTH: next_r.hth = bus.sfr_wdata;
                            `RCU_A_SEC: next_r.sec = bus.sfr_wdata;
                            `RCU_A_MIN: next_r.min = bus.sfr_wdata;
                            default: next_r.hour = bus.sfr_wdata;
                        endcase
                    end
                end
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Events: set wins over a same-cycle clear
        if (midnight) next_r.cfg[`RCU_B_MIDN] = 1'b1;
        if (alarm) next_r.cfg[`RCU_B_ALRM] = 1'b1;
        if (bus.irq_vector_ack && r.pend && r.ie2[`RCU_B_ETI]) next_r.pend = 1'b0;
        if (midnight || alarm) next_r.pend = 1'b1;
        next_r.wake = bus.deep_sleep && r.pend;

        case (rcu_pkg::rcu_fsel_e'(r.pin[6:5]))
            rcu_pkg::RCU_F_1HZ: next_r.cal = r.div[14];
            rcu_pkg::RCU_F_512HZ: next_r.cal = r.div[5];
            rcu_pkg::RCU_F_500HZ: next_r.cal = r.sq500;
            rcu_pkg::RCU_F_16K: next_r.cal = r.div[0];
            default: next_r.cal = 1'b0;
        endcase
        next_r.cal = next_r.cal && r.pin[`RCU_B_CALEN];

        case (bus.sfr_addr)
            `RCU_A_CFG: next_r.rdata = r.cfg;
            `RCU_A_HTH: next_r.rdata = r.hth;
            `RCU_A_SEC: next_r.rdata = r.sec;
            `RCU_A_MIN: next_r.rdata = r.min;
            `RCU_A_HOUR: next_r.rdata = r.hour;
            `RCU_A_IVAL: next_r.rdata = r.ival;
            `RCU_A_IE2: next_r.rdata = r.ie2;
            `RCU_A_KEY: next_r.rdata = r.key;
            `RCU_A_PWR: next_r.rdata = r.pwr;
            `RCU_A_NOM: next_r.rdata = r.nom;
            `RCU_A_TEMP: next_r.rdata = r.temp;
            `RCU_A_PIN: next_r.rdata = r.pin;
            default: next_r.rdata = 8'h00;
        endcase
        if (!bus.sfr_re) next_r.rdata = r.rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register: rst is power-on, warm_rst is watchdog or pin reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
        end else if (warm_rst) begin
            r <= next_r;
            // Trims and counters ride through a warm reset
            r.key <= 8'h00;
            r.pin <= 8'h00;
            r.ie2 <= 8'h00;
            r.pend <= 1'b0;
            r.wake <= 1'b0;
            r.cal <= 1'b0;
            r.rdata <= 8'h00;
            r.pwr_we <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign bus.sfr_rdata = r.rdata;
    assign bus.clk_irq_request = r.pend && r.ie2[`RCU_B_ETI];
    assign bus.wake = r.wake;
    assign cal_out = r.cal;
    assign cal_oe_n = !r.pin[`RCU_B_CALEN];
    assign ext_irq0_enable = r.pin[0];
    assign ext_irq1_gpio = (r.pin[2:1] == 2'b00);
    assign battery_control_input = (r.pin[2:1] == 2'b01);
    assign ext_irq1_enable = (r.pin[3:2] == 2'b11);
    assign power_control = r.pwr;
    assign power_control_we = r.pwr_we;
endmodule

/* File: hw/rcu_host.sv */
// Core end: turns user requests into unlocked writes, plain reads,
// coherent time reads, and vectors the clock interrupt.
`timescale 1ns/1ps
`include "rcu_consts.svh"
module rcu_host (
    input wire logic sys_clk,
    input wire logic rst,
    rcu_if.host bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_time,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic sleep_req,
    output logic resp_valid,
    output logic [31:0] resp_data,
    output logic irq_taken
);
    typedef struct packed {
        rcu_pkg::rcu_hstate_e st;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [2:0] idx;
        logic [39:0] snap;
        logic [31:0] data;
        logic rv;
        logic it;
    } rcu_host_s;

    rcu_host_s r;
    rcu_host_s next_r;
    logic prot;
    logic [7:0] taddr;

    always_comb begin
        next_r = r;
        next_r.rv = 1'b0;
        next_r.it = 1'b0;
        bus.sfr_we = 1'b0;
        bus.sfr_re = 1'b0;
        bus.sfr_addr = r.addr;
        bus.sfr_wdata = r.wdata;
        bus.irq_vector_ack = 1'b0;
        prot = (r.addr == `RCU_A_PWR) || (r.addr == `RCU_A_PIN)
            || (r.addr >= `RCU_A_HTH && r.addr <= `RCU_A_HOUR);
        taddr = (r.idx == 3'd4) ? `RCU_A_HTH : 8'(`RCU_A_HTH + 8'(r.idx));
        case (r.st)
            rcu_pkg::H_IDLE: begin
                if (bus.clk_irq_request) begin
                    next_r.st = rcu_pkg::H_ACK;
                end else if (req_valid) begin
                    next_r.addr = req_addr;
                    next_r.wdata = req_wdata;
                    next_r.idx = 3'd0;
                    next_r.st = req_time ? rcu_pkg::H_TIME
                        : (req_write ? rcu_pkg::H_KEY : rcu_pkg::H_RD);
                end
            end
            rcu_pkg::H_KEY: begin
                if (prot) begin
                    bus.sfr_we = 1'b1;
                    bus.sfr_addr = `RCU_A_KEY;
                    bus.sfr_wdata = (r.addr == `RCU_A_PWR) ? `RCU_KEY_PWR : `RCU_KEY_TIME;
                end
                next_r.st = rcu_pkg::H_WR;
            end
            rcu_pkg::H_WR: begin
                bus.sfr_we = 1'b1;
                bus.sfr_wdata = (r.addr == `RCU_A_PIN) ? (r.wdata & 8'hEF) : r.wdata;
                next_r.st = (prot && r.addr != `RCU_A_PWR) ? rcu_pkg::H_CLR : rcu_pkg::H_DONE;
            end
            rcu_pkg::H_CLR: begin
                bus.sfr_we = 1'b1;
                bus.sfr_addr = `RCU_A_KEY;
                bus.sfr_wdata = 8'h00;
                next_r.st = rcu_pkg::H_DONE;
            end
            rcu_pkg::H_RD: begin
                bus.sfr_re = 1'b1;
                next_r.st = rcu_pkg::H_RDW;
            end
            rcu_pkg::H_RDW: begin
                next_r.data = {24'h000000, bus.sfr_rdata};
                next_r.st = rcu_pkg::H_DONE;
            end
            rcu_pkg::H_TIME: begin
                bus.sfr_re = 1'b1;
                bus.sfr_addr = taddr;
                next_r.st = rcu_pkg::H_TW;
            end
            rcu_pkg::H_TW: begin
                next_r.snap = {bus.sfr_rdata, r.snap[39:8]};
                next_r.idx = r.idx + 3'd1;
                next_r.st = rcu_pkg::H_TIME;
                if (r.idx == 3'd4) begin
                    next_r.idx = 3'd0;
                    // Counter rolled mid-read: take the whole set again
                    if (bus.sfr_rdata == r.snap[15:8]) begin
                        next_r.data = r.snap[39:8];
                        next_r.st = rcu_pkg::H_DONE;
                    end
                end
            end
            rcu_pkg::H_ACK: begin
                bus.irq_vector_ack = 1'b1;
                next_r.it = 1'b1;
                next_r.st = rcu_pkg::H_IDLE;
            end
            rcu_pkg::H_DONE: begin
                next_r.rv = 1'b1;
                next_r.st = rcu_pkg::H_IDLE;
            end
            default: next_r.st = rcu_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Sleep is refused while a clock interrupt waits for service
    assign bus.deep_sleep = sleep_req && !bus.clk_irq_request;
    assign req_ready = (r.st == rcu_pkg::H_IDLE) && !bus.clk_irq_request;
    assign resp_valid = r.rv;
    assign resp_data = r.data;
    assign irq_taken = r.it;
endmodule

/* File: hw/rcu_if.sv */
// Special-function register link between core and clock block.
// Both ends share sys_clk; no tristate here.
`timescale 1ns/1ps
interface rcu_if;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_we;
    logic sfr_re;
    logic [7:0] sfr_rdata;
    logic clk_irq_request;
    logic irq_vector_ack;
    logic deep_sleep;
    logic wake;
    modport device (
        input sfr_addr, sfr_wdata, sfr_we, sfr_re, irq_vector_ack, deep_sleep,
        output sfr_rdata, clk_irq_request, wake
    );
    modport host (
        output sfr_addr, sfr_wdata, sfr_we, sfr_re, irq_vector_ack, deep_sleep,
        input sfr_rdata, clk_irq_request, wake
    );
endinterface

/* File: hw/rcu_pkg.sv */
// Types shared by both ends of the block.
// Assumes rcu_consts.svh is on the include path.
package rcu_pkg;
    typedef enum logic [1:0] {RCU_F_1HZ, RCU_F_512HZ, RCU_F_500HZ, RCU_F_16K} rcu_fsel_e;
    typedef enum logic [1:0] {RCU_IT_128, RCU_IT_SEC, RCU_IT_MIN, RCU_IT_HOUR} rcu_itbase_e;
    typedef enum {H_IDLE, H_KEY, H_WR, H_CLR, H_RD, H_RDW, H_TIME, H_TW, H_ACK, H_DONE} rcu_hstate_e;
endpackage

/* File: verification/rcu_monitor.sv */
// Checker for the core-to-clock register link.
// Instantiated beside the interface; sees only its signals.
`timescale 1ns/1ps
module rcu_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    input wire logic [7:0] sfr_rdata,
    input wire logic clk_irq_request,
    input wire logic irq_vector_ack,
    input wire logic deep_sleep,
    input wire logic wake
);
    logic [7:0] key;
    logic prot;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    assign prot = sfr_addr == 8'hFF || sfr_addr == 8'hC5 ||
        (sfr_addr >= 8'hA2 && sfr_addr <= 8'hA5);
    // Shadow of the key; warm resets only ever find it zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            key <= 8'h00;
        end else if (sfr_we && sfr_addr == 8'hC1) begin
            key <= sfr_wdata;
        end else if (sfr_we && prot) begin
            key <= 8'h00;
        end
    end
    //////////////////////////////
    property p_time_key;
        sfr_we && prot && sfr_addr != 8'hC5 |-> key == 8'hEA;
    endproperty
    a_time_key: assert property (p_time_key) else $error("protected write without key");
    property p_pwr_key;
        sfr_we && sfr_addr == 8'hC5 |-> key == 8'hA7;
    endproperty
    a_pwr_key: assert property (p_pwr_key) else $error("power write without key");
    property p_key_read;
        sfr_re && sfr_addr == 8'hC1 |=> sfr_rdata == $past(key);
    endproperty
    a_key_read: assert property (p_key_read) else $error("key not spent by write");
    property p_pin_mask;
        sfr_we && sfr_addr == 8'hFF |-> !sfr_wdata[4];
    endproperty
    a_pin_mask: assert property (p_pin_mask) else $error("reserved pin bit written");
    property p_ack_cause;
        irq_vector_ack |-> $past(clk_irq_request);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("vector without request");
    property p_ack_clears;
        irq_vector_ack |=> !clk_irq_request;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("pending kept after vector");
    property p_serve;
        $rose(clk_irq_request) |-> ##[1:300] irq_vector_ack;
    endproperty
    a_serve: assert property (p_serve) else $error("enabled request not vectored");
    property p_wake_cause;
        wake |-> $past(deep_sleep);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake while awake");
    property p_wake_hold;
        wake && deep_sleep && !irq_vector_ack && !$past(irq_vector_ack) |=> wake;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake dropped while pending");
    c_vector: cover property (irq_vector_ack);
    c_wake: cover property ($rose(wake));
    c_hour_write: cover property (sfr_we && sfr_addr == 8'hA5);
endmodule

/* File: verification/test_rtc_calib_unlock_and_events.sv */
// Bench: host and clock ends joined by rcu_if, plus a second clock
// end driven directly to try writes with a wrong or spent key.
`timescale 1ns/1ps
module test_rtc_calib_unlock_and_events;
    logic sys_clk = 0;
    logic rst = 1;
    logic warm_rst = 0;
    logic xtal = 0;
    logic req_valid = 0;
    logic req_write = 0;
    logic req_time = 0;
    logic [7:0] req_addr = 8'h00;
    logic [7:0] req_wdata = 8'h00;
    logic sleep_req = 0;
    logic req_ready, resp_valid, irq_taken, cal_out, cal_oe_n, pwr_we;
    logic irq0_en, irq1_en, irq1_gpio, bat_in;
    logic [7:0] pwr, pwr_b, v;
    logic [31:0] resp_data;
    logic [7:0] mreg [256];
    logic [7:0] lim [4] = '{8'h64, 8'h3C, 8'h3C, 8'h18};
    logic [7:0] probe [5] = '{8'hF7, 8'hFF, 8'hC1, 8'hF6, 8'h80};
    int lo [4] = '{0, 63, 61, 2047};
    int hi [4] = '{1, 65, 64, 2049};
    int fail_count = 0;
    int tests_run = 0;
    int seed = 32'hd47d;
    int n, edges;
    rcu_if link ();
    rcu_if side ();
    rcu_device rcu_device_inst (.sys_clk(sys_clk), .rst(rst), .warm_rst(warm_rst),
        .bus(link), .xtal_pulse(xtal), .cal_out(cal_out), .cal_oe_n(cal_oe_n),
        .ext_irq0_enable(irq0_en), .ext_irq1_enable(irq1_en), .ext_irq1_gpio(irq1_gpio),
        .battery_control_input(bat_in), .power_control(pwr), .power_control_we());
    rcu_device rcu_device_inst_b (.sys_clk(sys_clk), .rst(rst), .warm_rst(warm_rst),
        .bus(side), .xtal_pulse(xtal), .cal_out(), .cal_oe_n(), .ext_irq0_enable(),
        .ext_irq1_enable(), .ext_irq1_gpio(), .battery_control_input(),
        .power_control(pwr_b), .power_control_we(pwr_we));
    rcu_host rcu_host_inst (.sys_clk(sys_clk), .rst(rst), .bus(link),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_time(req_time), .req_addr(req_addr), .req_wdata(req_wdata),
        .sleep_req(sleep_req), .resp_valid(resp_valid), .resp_data(resp_data),
        .irq_taken(irq_taken));
    rcu_monitor rcu_monitor_inst (.sys_clk(sys_clk), .rst(rst), .sfr_addr(link.sfr_addr),
        .sfr_wdata(link.sfr_wdata), .sfr_we(link.sfr_we), .sfr_re(link.sfr_re),
        .sfr_rdata(link.sfr_rdata), .clk_irq_request(link.clk_irq_request),
        .irq_vector_ack(link.irq_vector_ack), .deep_sleep(link.deep_sleep), .wake(link.wake));
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge cal_out) edges++;
    //////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One host request; all tasks return just after a falling edge
    task automatic op(input logic w, input logic t, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(negedge sys_clk);
        req_valid = 1;
        req_write = w;
        req_time = t;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && k < 500) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        req_valid = 0;
        req_wdata = ~d;
        while (resp_valid !== 1'b1 && k < 500) begin
            @(negedge sys_clk);
            k++;
        end
        chk(k < 500, 1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1, 0, a, d);
        // Config bits land only on a slow tick, so the scenario sets them
        if (a != 8'hA1) begin
            mreg[a] = a == 8'hFF ? d & 8'hEF : d;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        op(0, 0, a, 8'h00);
        chk(resp_data[7:0], mreg[a]);
    endtask
    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        side.sfr_we = 1;
        side.sfr_addr = a;
        side.sfr_wdata = d;
        @(negedge sys_clk);
        side.sfr_we = 0;
        side.sfr_wdata = ~d;
    endtask
    task automatic br(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        side.sfr_re = 1;
        side.sfr_addr = a;
        @(negedge sys_clk);
        side.sfr_re = 0;
        @(negedge sys_clk);
        chk(side.sfr_rdata, e);
    endtask
    task automatic tick(input int c);
        xtal = 1;
        repeat (c) @(negedge sys_clk);
        xtal = 0;
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    //////////////////////////////
    initial begin
        side.sfr_we = 0;
        side.sfr_re = 0;
        side.sfr_addr = 8'h00;
        side.sfr_wdata = 8'h00;
        side.irq_vector_ack = 0;
        side.deep_sleep = 0;
        foreach (mreg[i]) mreg[i] = 8'h00;
        repeat (4) @(negedge sys_clk);
        rst = 0;
        foreach (probe[i]) rd(probe[i]);
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            v[3:0] = i[3:0];
            wr(8'hFF, v);
            rd(8'hFF);
            chk(irq0_en, v[0]);
            chk(irq1_gpio, v[2:1] == 2'h0);
            chk(bat_in, v[2:1] == 2'h1);
            chk(irq1_en, v[3:2] == 2'h3);
            chk(cal_oe_n, !v[7]);
        end
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(8'hA2 + 8'(i), v % lim[i]);
        end
        op(0, 1, 8'h00, 8'h00);
        chk(resp_data, {mreg[8'hA5], mreg[8'hA4], mreg[8'hA3], mreg[8'hA2]});
        rd(8'hC1);
        v = $random(seed);
        wr(8'hC5, v);
        chk(pwr, v);
        // Second end: spent, wrong and mismatched keys
        bw(8'hA3, 8'h11);
        br(8'hA3, 8'h00);
        bw(8'hC1, 8'hEA);
        bw(8'hA3, 8'h22);
        bw(8'hA3, 8'h33);
        br(8'hA3, 8'h22);
        bw(8'hC1, 8'hA7);
        bw(8'hA3, 8'h44);
        br(8'hA3, 8'h22);
        bw(8'hC5, 8'h5A);
        chk(pwr_we, 1);
        chk(pwr_b, 8'h5A);
        bw(8'hC1, 8'hEA);
        bw(8'hC5, 8'h3C);
        chk(pwr_we, 0);
        chk(pwr_b, 8'h5A);
        bw(8'hC1, 8'h12);
        bw(8'hFF, 8'h81);
        br(8'hFF, 8'h00);
        br(8'hC1, 8'h12);
        wr(8'hA1, 8'h10);
        rd(8'hA1);
        tick(512);
        mreg[8'hA1] = 8'h10;
        rd(8'hA1);
        for (int m = 1; m >= 0; m--) begin
            mreg[8'hA1] = m ? 8'h10 : 8'h00;
            wr(8'hA1, mreg[8'hA1]);
            tick(512);
            wr(8'hA5, m ? 8'h17 : 8'hFF);
            wr(8'hA4, 8'h3B);
            wr(8'hA3, 8'h3B);
            wr(8'hA2, 8'h63);
            sleep_req = 1;
            xtal = 1;
            n = 0;
            while (link.wake !== 1'b1 && n < 2000) begin
                @(negedge sys_clk);
                n++;
            end
            xtal = 0;
            chk(n < 2000, 1);
            chk(link.clk_irq_request, 0);
            repeat (20) @(negedge sys_clk);
            chk(link.wake, 1);
            sleep_req = 0;
            mreg[8'hA1][6] = 1'b1;
            rd(8'hA1);
            op(0, 1, 8'h00, 8'h00);
            chk(resp_data[31:24], 8'h00);
            wr(8'hA9, 8'h04);
            n = 0;
            while (irq_taken !== 1'b1 && n < 50) begin
                @(negedge sys_clk);
                n++;
            end
            chk(n < 50, 1);
            rd(8'hA1);
            mreg[8'hA1][6] = 1'b0;
            wr(8'hA1, mreg[8'hA1]);
            rd(8'hA1);
            wr(8'hA9, 8'h00);
        end
        wr(8'hF7, 8'h55);
        warm_rst = 1;
        @(negedge sys_clk);
        warm_rst = 0;
        mreg[8'hFF] = 8'h00;
        rd(8'hF7);
        rd(8'hFF);
        rst = 1;
        @(negedge sys_clk);
        rst = 0;
        foreach (mreg[i]) mreg[i] = 8'h00;
        rd(8'hF7);
        for (int f = 0; f < 4; f++) begin
            wr(8'hFF, 8'h80 | 8'(f << 5));
            wr(8'hA2, 8'h00);
            wr(8'hA3, 8'h00);
            edges = 0;
            tick(4096);
            chk(edges >= lo[f] && edges <= hi[f], 1);
            op(0, 1, 8'h00, 8'h00);
            chk(resp_data[15:8], f[1] ? 8'h0F : 8'h00);
        end
        wr(8'hF7, 8'h80);
        wr(8'hF6, 8'h80);
        wr(8'hA6, 8'h02);
        wr(8'hA1, 8'h02);
        edges = 0;
        tick(16400);
        chk(edges, 32'h2004);
        mreg[8'hA1] = 8'h22;
        rd(8'hA1);
        rd(8'hA6);
        close_out();
    end
    // Whole run is about 35400 cycles; 60000 means a hang
    initial begin
        #(40 * 60000);
        fail_count++;
        close_out();
    end
endmodule
